// ### tmr2_pkg.sv
// timer 2 package: register indices, control bit positions, reset values, timing.
// assumes an 8-bit register port with byte-wide registers at their printed offsets.
package tmr2_pkg;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL    = 8'hC8;
	localparam logic [7:0] OFS_MODE    = 8'hC9;
	localparam logic [7:0] OFS_CAP_LO  = 8'hCA;
	localparam logic [7:0] OFS_CAP_HI  = 8'hCB;
	localparam logic [7:0] OFS_CNT_LO  = 8'hCC;
	localparam logic [7:0] OFS_CNT_HI  = 8'hCD;
	localparam logic [7:0] OFS_BITSET  = 8'hCE;
	localparam logic [7:0] OFS_BITCLR  = 8'hCF;
	localparam logic [7:0] OFS_IRQ_ST  = 8'hD8;
	localparam logic [7:0] OFS_IRQ_MSK = 8'hD9;
	localparam logic [7:0] OFS_SER     = 8'hDA;
	// ---------------------------------------------------------------
	// control and mode register bit positions
	// ---------------------------------------------------------------
	localparam int B_OVF   = 7;
	localparam int B_EXT   = 6;
	localparam int B_RXB   = 5;
	localparam int B_TXB   = 4;
	localparam int B_TEN   = 3;
	localparam int B_RUN   = 2;
	localparam int B_CSEL  = 1;
	localparam int B_CRSEL = 0;
	localparam int B_UPDN  = 0;
	// ---------------------------------------------------------------
	// reset values and timing
	// ---------------------------------------------------------------
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [15:0] RST_WORD   = 16'h0000;
	localparam logic [15:0] CNT_MAX    = 16'hFFFF;
	localparam int          CLK_HZ     = 25000000;
	localparam int          TICK_DIV   = 12;
	localparam logic [3:0]  TICK_LAST  = 4'(TICK_DIV - 1);
	// irq status bits
	localparam int I_OVF = 0;
	localparam int I_EXT = 1;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} tmr2_bus_t;
endpackage : tmr2_pkg

// ### tmr2_top.sv
// timer 2: 16-bit timer/counter with capture, auto-reload and baud outputs.
// assumes pins are asynchronous and a single-master byte register port.
//
// Behaviour
// [R1] overflow sets sticky flag, only software clears
// [R2] no overflow flag while baud selected
// [R3] trigger capture/reload sets external flag
// [R4] external flag requests timer interrupt
// [R5] no external-flag interrupt in up/down mode
// [R6] receive clock from this timer or timer 1
// [R7] transmit clock from this timer or timer 1
// [R8] trigger acts only when not baud clocking
// [R9] trigger ignored while trigger enable clear
// [R10] run control starts and stops counting
// [R11] select internal ticks or count pin falls
// [R12] capture mode: trigger fall captures count
// [R13] reload mode: reload on overflow and trigger
// [R14] baud mode forces reload on overflow
// [R15] capture pair holds captured or reload value
// [R16] control resets zero, bits individually settable
// [R17] count and trigger pins are shared inputs
// [R18] capture copies count, reload loads count
// [R19] count is two software-accessible bytes
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module tmr2_top (
	// clock and reset
	input  wire logic            core_clk,
	input  wire logic            rst_b,
	// register port
	input  wire tmr2_pkg::tmr2_bus_t bus,
	output var  logic [7:0]      rdata,
	// pins
	input  wire logic            count_pin,
	input  wire logic            trigger_pin,
	// serial baud sources
	input  wire logic            t1_ovf,
	output var  logic            rx_baud_tick,
	output var  logic            tx_baud_tick,
	// interrupts
	output var  logic            tmr_irq,
	output var  logic            irq
);
	// ---------------------------------------------------------------
	// pin synchronisers and edge detect
	// ---------------------------------------------------------------
	logic [1:0] cnt_sync_r;
	logic [1:0] trg_sync_r;
	logic       cnt_prev_r;
	logic       trg_prev_r;
	// two stages before any logic looks at the pins [R17]
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
		begin
			cnt_sync_r <= 2'h3;
			trg_sync_r <= 2'h3;
			cnt_prev_r <= 1'b1;
			trg_prev_r <= 1'b1;
		end
		else
		begin
			cnt_sync_r <= {cnt_sync_r[0], count_pin};
			trg_sync_r <= {trg_sync_r[0], trigger_pin};
			cnt_prev_r <= cnt_sync_r[1];
			trg_prev_r <= trg_sync_r[1];
		end
	wire cnt_fall = cnt_prev_r & ~cnt_sync_r[1];
	wire trg_fall = trg_prev_r & ~trg_sync_r[1];

	// ---------------------------------------------------------------
	// internal tick divider
	// ---------------------------------------------------------------
	logic [3:0] div_r;
	// one-cycle tick every twelve core clocks, the machine-cycle rate
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			div_r <= 4'h0;
		else if (div_r == tmr2_pkg::TICK_LAST)
			div_r <= 4'h0;
		else
			div_r <= div_r + 4'h1;
	wire tick = (div_r == tmr2_pkg::TICK_LAST);

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0]  ctrl_r;
	logic        updn_r;
	logic [15:0] cap_r;
	logic [15:0] cnt_r;
	logic [1:0]  ist_r;
	logic [1:0]  imsk_r;
	logic        ser_m13_r;
	wire wr_ctrl = bus.wr & (bus.addr == tmr2_pkg::OFS_CTRL);
	wire wr_bset = bus.wr & (bus.addr == tmr2_pkg::OFS_BITSET);
	wire wr_bclr = bus.wr & (bus.addr == tmr2_pkg::OFS_BITCLR);
	wire wr_clo  = bus.wr & (bus.addr == tmr2_pkg::OFS_CNT_LO);
	wire wr_chi  = bus.wr & (bus.addr == tmr2_pkg::OFS_CNT_HI);
	wire wr_rlo  = bus.wr & (bus.addr == tmr2_pkg::OFS_CAP_LO);
	wire wr_rhi  = bus.wr & (bus.addr == tmr2_pkg::OFS_CAP_HI);
	wire baud    = ctrl_r[tmr2_pkg::B_RXB] | ctrl_r[tmr2_pkg::B_TXB];

	// ---------------------------------------------------------------
	// counting engine
	// ---------------------------------------------------------------
	// count source: internal tick or falling count pin [R11], gated by run [R10]
	wire cnt_en  = ctrl_r[tmr2_pkg::B_RUN] &
		(ctrl_r[tmr2_pkg::B_CSEL] ? cnt_fall : tick); // [R10] [R11]
	// up/down mode: trigger level steers direction
	wire dn_mode = updn_r & ~baud & ~trg_sync_r[1];
	wire ovf     = cnt_en & ~dn_mode & (cnt_r == tmr2_pkg::CNT_MAX);
	wire unf     = cnt_en & dn_mode & (cnt_r == cap_r);
	// trigger events only when enabled and not baud clocking [R8] [R9]
	wire trg_ev  = trg_fall & ctrl_r[tmr2_pkg::B_TEN] & ~baud & ~updn_r;
	wire cap_md  = ctrl_r[tmr2_pkg::B_CRSEL] & ~baud; // baud forces reload [R14]
	wire do_cap  = trg_ev & cap_md;                                // [R12]
	wire do_rld  = (ovf & (~cap_md)) | (trg_ev & ~cap_md);          // [R13] [R14]

	// count register; software byte writes win over hardware [R19]
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			cnt_r <= tmr2_pkg::RST_WORD;
		else if (wr_clo)
			cnt_r[7:0] <= bus.wdata;
		else if (wr_chi)
			cnt_r[15:8] <= bus.wdata;
		else if (do_rld)
			cnt_r <= cap_r;                                     // [R18]
		else if (unf)
			cnt_r <= tmr2_pkg::CNT_MAX;
		else if (cnt_en)
			cnt_r <= dn_mode ? cnt_r - 16'h0001 : cnt_r + 16'h0001;

	// capture/reload pair [R15]
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			cap_r <= tmr2_pkg::RST_WORD;
		else if (do_cap)
			cap_r <= cnt_r;                                     // [R18] [R15]
		else if (wr_rlo)
			cap_r[7:0] <= bus.wdata;
		else if (wr_rhi)
			cap_r[15:8] <= bus.wdata;

	// ---------------------------------------------------------------
	// control register with hardware-set flags
	// ---------------------------------------------------------------
	logic [7:0] ctrl_nxt;
	wire ovf_set = (ovf | unf) & ~baud;                            // [R1] [R2]
	wire ext_set = do_cap | (trg_ev & ~cap_md);                    // [R3]
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl)
			ctrl_nxt = bus.wdata;
		else if (wr_bset)
			ctrl_nxt = ctrl_r | bus.wdata;                      // [R16]
		else if (wr_bclr)
			ctrl_nxt = ctrl_r & ~bus.wdata;                     // [R16]
		// hardware set wins over a same-cycle clear
		if (ovf_set)
			ctrl_nxt[tmr2_pkg::B_OVF] = 1'b1;                   // [R1]
		if (ext_set)
			ctrl_nxt[tmr2_pkg::B_EXT] = 1'b1;                   // [R3]
	end
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			ctrl_r <= tmr2_pkg::RST_BYTE;                       // [R16]
		else
			ctrl_r <= ctrl_nxt;

	// mode register and serial mode hint
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
		begin
			updn_r    <= 1'b0;
			ser_m13_r <= 1'b0;
		end
		else
		begin
			if (bus.wr & (bus.addr == tmr2_pkg::OFS_MODE))
				updn_r <= bus.wdata[tmr2_pkg::B_UPDN];
			if (bus.wr & (bus.addr == tmr2_pkg::OFS_SER))
				ser_m13_r <= bus.wdata[0];
		end

	// ---------------------------------------------------------------
	// baud tick outputs
	// ---------------------------------------------------------------
	// in modes 1 and 3 pick this timer's overflow or timer 1's [R6] [R7]
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
		begin
			rx_baud_tick <= 1'b0;
			tx_baud_tick <= 1'b0;
		end
		else
		begin
			rx_baud_tick <= (ser_m13_r & ctrl_r[tmr2_pkg::B_RXB]) ? ovf : t1_ovf; // [R6]
			tx_baud_tick <= (ser_m13_r & ctrl_r[tmr2_pkg::B_TXB]) ? ovf : t1_ovf; // [R7]
		end

	// ---------------------------------------------------------------
	// interrupts
	// ---------------------------------------------------------------
	// timer interrupt: flags, external flag suppressed in up/down [R4] [R5]
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			tmr_irq <= 1'b0;
		else
			tmr_irq <= ctrl_nxt[tmr2_pkg::B_OVF] |
				(ctrl_nxt[tmr2_pkg::B_EXT] & ~updn_r);          // [R4] [R5]

	// sticky status, write one to clear, set wins
	logic [1:0] ist_nxt;
	always_comb
	begin
		ist_nxt = ist_r;
		if (bus.wr & (bus.addr == tmr2_pkg::OFS_IRQ_ST))
			ist_nxt = ist_r & ~bus.wdata[1:0];
		if (ovf_set)
			ist_nxt[tmr2_pkg::I_OVF] = 1'b1;
		if (ext_set & ~updn_r)
			ist_nxt[tmr2_pkg::I_EXT] = 1'b1;                    // [R5]
	end
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
		begin
			ist_r  <= 2'h0;
			imsk_r <= 2'h0;
			irq    <= 1'b0;
		end
		else
		begin
			ist_r <= ist_nxt;
			if (bus.wr & (bus.addr == tmr2_pkg::OFS_IRQ_MSK))
				imsk_r <= bus.wdata[1:0];
			irq <= |(ist_nxt & imsk_r);
		end

	// ---------------------------------------------------------------
	// read port, data one cycle after the strobe; unmapped reads zero
	// ---------------------------------------------------------------
	logic [7:0] rd_nxt;
	always_comb
	begin
		rd_nxt = 8'h00;
		unique case (bus.addr)
			tmr2_pkg::OFS_CTRL:    rd_nxt = ctrl_r;
			tmr2_pkg::OFS_MODE:    rd_nxt = {7'h00, updn_r};
			tmr2_pkg::OFS_CAP_LO:  rd_nxt = cap_r[7:0];
			tmr2_pkg::OFS_CAP_HI:  rd_nxt = cap_r[15:8];
			tmr2_pkg::OFS_CNT_LO:  rd_nxt = cnt_r[7:0];
			tmr2_pkg::OFS_CNT_HI:  rd_nxt = cnt_r[15:8];
			tmr2_pkg::OFS_IRQ_ST:  rd_nxt = {6'h00, ist_r};
			tmr2_pkg::OFS_IRQ_MSK: rd_nxt = {6'h00, imsk_r};
			tmr2_pkg::OFS_SER:     rd_nxt = {7'h00, ser_m13_r};
			default:               rd_nxt = 8'h00;
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			rdata <= 8'h00;
		else
			rdata <= bus.rd ? rd_nxt : 8'h00;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	a_ovf_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_b) // [R1]
		ovf_set |=> ctrl_r[tmr2_pkg::B_OVF]) else $error("overflow flag not set");
	a_ovf_baud_quiet: assert property (@(posedge core_clk) disable iff (!rst_b) // [R2]
		(ovf & baud & !ctrl_r[tmr2_pkg::B_OVF] & !wr_ctrl & !wr_bset)
		|=> !ctrl_r[tmr2_pkg::B_OVF]) else $error("overflow flag set in baud mode");
	a_ovf_sticky: assert property (@(posedge core_clk) disable iff (!rst_b) // [R1]
		(ctrl_r[tmr2_pkg::B_OVF] & !wr_ctrl & !wr_bclr) |=> ctrl_r[tmr2_pkg::B_OVF])
		else $error("overflow flag cleared by hardware");
	a_ext_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_b) // [R3]
		trg_ev |=> ctrl_r[tmr2_pkg::B_EXT]) else $error("trigger flag not set");
	a_trig_ignored: assert property (@(posedge core_clk) disable iff (!rst_b) // [R9]
		!ctrl_r[tmr2_pkg::B_TEN] |-> !do_cap) else $error("capture without enable");
	a_capture_value: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
		do_cap |=> cap_r == $past(cnt_r)) else $error("capture value wrong");
	a_reload_value: assert property (@(posedge core_clk) disable iff (!rst_b) // [R13]
		(ovf & !cap_md & !wr_clo & !wr_chi) |=> cnt_r == $past(cap_r))
		else $error("reload value wrong");
	// a trigger reload is not counting, so it may still move a stopped count
	a_stop_holds: assert property (@(posedge core_clk) disable iff (!rst_b) // [R10]
		(!ctrl_r[tmr2_pkg::B_RUN] & !trg_ev & !wr_clo & !wr_chi) |=> $stable(cnt_r))
		else $error("count moved while stopped");
	a_irq_updn: assert property (@(posedge core_clk) disable iff (!rst_b) // [R5]
		(updn_r & !ctrl_r[tmr2_pkg::B_OVF] & !ovf_set & !wr_ctrl & !wr_bset)
		|=> !tmr_irq) else $error("external flag interrupt in up/down mode");

	// ---------------------------------------------------------------
	// named sequences for the multi-step checks
	// ---------------------------------------------------------------
	// a trigger fall as the edge detector sees it, two stages after the pin
	sequence s_trig_fall;
		trg_sync_r[1] ##1 !trg_sync_r[1];
	endsequence

	// a fall that the enable lets through: not baud clocking, not up/down
	sequence s_trig_taken;
		s_trig_fall ##0 (ctrl_r[tmr2_pkg::B_TEN] & !baud & !updn_r);
	endsequence

	// an enabled fall while the timer clocks the serial port; no pair write
	sequence s_trig_in_baud;
		s_trig_fall ##0 (ctrl_r[tmr2_pkg::B_TEN] & baud & !wr_rlo & !wr_rhi);
	endsequence

	// one count step with no overflow, reload or software write beside it
	sequence s_plain_step;
		cnt_en & !ovf & !unf & !trg_ev & !wr_clo & !wr_chi;
	endsequence

	// ---------------------------------------------------------------
	// trigger and reload checks
	// ---------------------------------------------------------------
	// besides the pair or count it loads, the flag shows software a trigger event
	a_trig_flag: assert property (@(posedge core_clk) disable iff (!rst_b) // [R3]
		s_trig_taken |=> ctrl_r[tmr2_pkg::B_EXT])
		else $error("trigger fall left external flag clear");

	// baud clocking takes the trigger away, so the pair must not move
	a_baud_no_capture: assert property (@(posedge core_clk) disable iff (!rst_b) // [R8]
		s_trig_in_baud |=> $stable(cap_r))
		else $error("trigger acted while baud clocking");

	// a trigger reload works whether or not the timer is running
	a_trig_reload: assert property (@(posedge core_clk) disable iff (!rst_b) // [R13]
		(trg_ev & !cap_md & !wr_clo & !wr_chi) |=> cnt_r == $past(cap_r))
		else $error("trigger reload value wrong");

	// baud mode reloads on overflow even with capture selected
	a_baud_reload: assert property (@(posedge core_clk) disable iff (!rst_b) // [R14]
		(ovf & baud & !wr_clo & !wr_chi) |=> cnt_r == $past(cap_r))
		else $error("baud overflow did not reload");

	// ---------------------------------------------------------------
	// counting checks
	// ---------------------------------------------------------------
	// the divider must give exactly one tick in every twelve clocks
	a_tick_period: assert property (@(posedge core_clk) disable iff (!rst_b) // [R11]
		tick |-> ##12 tick)
		else $error("internal tick period wrong");

	// an ordinary step moves the count by one and by nothing else
	a_count_up: assert property (@(posedge core_clk) disable iff (!rst_b) // [R11]
		(s_plain_step ##0 !dn_mode) |=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("count did not step up");

	// trigger low in up/down mode steers the count downward
	a_count_down: assert property (@(posedge core_clk) disable iff (!rst_b) // [R17]
		(s_plain_step ##0 dn_mode) |=> cnt_r == $past(cnt_r) - 16'h0001)
		else $error("count did not step down");

	// underflow past the reload value wraps to the top of the range
	a_underflow_wrap: assert property (@(posedge core_clk) disable iff (!rst_b) // [R17]
		(unf & !wr_clo & !wr_chi) |=> cnt_r == tmr2_pkg::CNT_MAX)
		else $error("underflow did not wrap");

	// ---------------------------------------------------------------
	// baud source and interrupt checks
	// ---------------------------------------------------------------
	// the ticks lag their source by one clock, the price of registered outputs
	a_rx_from_ovf: assert property (@(posedge core_clk) disable iff (!rst_b) // [R6]
		(ser_m13_r & ctrl_r[tmr2_pkg::B_RXB] & ovf) |=> rx_baud_tick)
		else $error("receive tick missed this timer overflow");

	// with the select clear, timer 1 keeps driving the transmit side
	a_tx_from_t1: assert property (@(posedge core_clk) disable iff (!rst_b) // [R7]
		(!ctrl_r[tmr2_pkg::B_TXB] & t1_ovf) |=> tx_baud_tick)
		else $error("transmit tick missed timer 1 overflow");

	// a standing external flag keeps the request up outside up/down mode
	a_irq_level: assert property (@(posedge core_clk) disable iff (!rst_b) // [R4]
		(ctrl_r[tmr2_pkg::B_EXT] & !updn_r & !wr_ctrl & !wr_bclr) |=> tmr_irq)
		else $error("external flag did not request interrupt");

	// software clear must take effect when no overflow lands beside it
	a_sw_clear: assert property (@(posedge core_clk) disable iff (!rst_b) // [R1]
		(wr_bclr & bus.wdata[tmr2_pkg::B_OVF] & !ovf_set) |=> !ctrl_r[tmr2_pkg::B_OVF])
		else $error("overflow flag survived a software clear");
endmodule : tmr2_top
`default_nettype wire

// ### tmr2_pins_model.sv
// far side of the timer: count pin, trigger pin and timer 1 overflow.
// assumes the testbench calls these tasks from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module tmr2_pins_model (
	// clock
	input  wire logic core_clk,
	// pins toward the timer
	output var  logic count_pin,
	output var  logic trigger_pin,
	output var  logic t1_ovf
);
	// port pins idle high through their pull-ups
	initial
	begin
		count_pin   = 1'b1;
		trigger_pin = 1'b1;
		t1_ovf      = 1'b0;
	end

	// each level held four cycles so the two-stage sync cannot miss it
	task pulse_count(input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			count_pin <= 1'b0;
			repeat (4) @(posedge core_clk);
			count_pin <= 1'b1;
			repeat (4) @(posedge core_clk);
		end
	endtask : pulse_count

	task fall_trigger();
		@(posedge core_clk);
		trigger_pin <= 1'b0;
		repeat (6) @(posedge core_clk);
		trigger_pin <= 1'b1;
		repeat (6) @(posedge core_clk);
	endtask : fall_trigger

	// hold the trigger at a level; in up/down mode it steers the direction
	task hold_trigger(input logic lvl);
		@(posedge core_clk);
		trigger_pin <= lvl;
		repeat (3) @(posedge core_clk);
	endtask : hold_trigger

	task t1_pulse();
		@(posedge core_clk);
		t1_ovf <= 1'b1;
		@(posedge core_clk);
		t1_ovf <= 1'b0;
	endtask : t1_pulse
endmodule : tmr2_pins_model
`default_nettype wire

// ### test_timer2_capture_reload_control.sv
// self-checking bench for the timer: register port here, pins in the partner.
// assumes a one-cycle read latency and pin events settling within six cycles.
`timescale 1ns/1ps
`default_nettype none
module test_timer2_capture_reload_control;
	// ---------------------------------------------------------------
	// nets
	// ---------------------------------------------------------------
	logic                core_clk = 1'b0;
	logic                rst_b    = 1'b0;
	tmr2_pkg::tmr2_bus_t bus      = '0;
	logic [7:0]          rdata;
	logic                count_pin;
	logic                trigger_pin;
	logic                t1_ovf;
	logic                rx_baud_tick;
	logic                tx_baud_tick;
	logic                tmr_irq;
	logic                irq;
	logic [7:0]          rv;
	int                  err_total   = 0;
	int                  check_count = 0;

	always #20 core_clk = ~core_clk;

	tmr2_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
		.count_pin(count_pin), .trigger_pin(trigger_pin), .t1_ovf(t1_ovf),
		.rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick),
		.tmr_irq(tmr_irq), .irq(irq));
	tmr2_pins_model u_pins (.core_clk(core_clk), .count_pin(count_pin),
		.trigger_pin(trigger_pin), .t1_ovf(t1_ovf));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task conclude();
		if (err_total == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	task check(input logic [7:0] seen, input logic [7:0] want);
		check_count++;
		if (seen !== want)
		begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus <= '0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task rd(input logic [7:0] a);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus <= '0;
		#1;
		rv = rdata;
	endtask : rd

	task idle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : idle

	// sel 0 waits for the timer interrupt, 1 for a receive baud tick
	task wait_ev(input int sel, input int lim);
		int n;
		for (n = 0; n < lim; n++)
		begin
			#1;
			if ((sel == 0 && tmr_irq === 1'b1) || (sel == 1 && rx_baud_tick === 1'b1))
				break;
			@(posedge core_clk);
		end
		if (n == lim)
		begin
			err_total++;
			$display("unexpected at %0t: wait ran out", $time);
			conclude();
		end
	endtask : wait_ev

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task sc_reset();
		logic [63:0] adrs;
		adrs = 64'hC8CACBCCCDD8D900;
		for (int i = 0; i < 8; i++)
		begin
			rd(adrs[63 - 8 * i -: 8]);
			check(rv, 8'h00);
		end
	endtask : sc_reset

	task sc_overflow();
		wr(8'hCA, 8'h34);
		wr(8'hCB, 8'h12);
		wr(8'hCC, 8'hF0);
		wr(8'hCD, 8'hFF);
		wr(8'hC8, 8'h04);
		wait_ev(0, 400);
		wr(8'hCF, 8'h04);
		rd(8'hCD);
		check(rv, 8'h12);
		idle(40);
		rd(8'hC8);
		check(rv, 8'h80);
		rd(8'hD8);
		check(rv, 8'h01);
		check({7'h00, irq}, 8'h00);
		wr(8'hD9, 8'h01);
		idle(3);
		check({7'h00, irq}, 8'h01);
		wr(8'hD8, 8'h01);
		idle(3);
		check({7'h00, irq}, 8'h00);
		wr(8'hCF, 8'h80);
		idle(3);
		check({7'h00, tmr_irq}, 8'h00);
		wr(8'hD9, 8'h00);
	endtask : sc_overflow

	// overflow of this timer feeds both baud ticks, no flag, forced reload
	task sc_baud();
		wr(8'hDA, 8'h01);
		wr(8'hCB, 8'h77);
		wr(8'hCC, 8'hF0);
		wr(8'hCD, 8'hFF);
		wr(8'hC8, 8'h35);
		wait_ev(1, 400);
		check({7'h00, tx_baud_tick}, 8'h01);
		wr(8'hCF, 8'h04);
		rd(8'hCD);
		check(rv, 8'h77);
		rd(8'hC8);
		check(rv, 8'h31);
		// an enabled trigger fall while baud clocking must do nothing
		wr(8'hCC, 8'h55);
		wr(8'hC8, 8'h39);
		u_pins.fall_trigger();
		rd(8'hCA);
		check(rv, 8'h34);
		rd(8'hCC);
		check(rv, 8'h55);
		rd(8'hC8);
		check(rv, 8'h39);
		wr(8'hC8, 8'h00);
		u_pins.t1_pulse();
		wait_ev(1, 4);
		check({7'h00, tx_baud_tick}, 8'h01);
		wr(8'hDA, 8'h00);
	endtask : sc_baud

	task sc_trigger();
		wr(8'hCC, 8'hCD);
		wr(8'hCD, 8'hAB);
		wr(8'hC8, 8'h09);
		u_pins.fall_trigger();
		rd(8'hCA);
		check(rv, 8'hCD);
		rd(8'hCB);
		check(rv, 8'hAB);
		rd(8'hC8);
		check(rv, 8'h49);
		check({7'h00, tmr_irq}, 8'h01);
		wr(8'hCF, 8'h40);
		wr(8'hC8, 8'h01);
		wr(8'hCC, 8'h66);
		u_pins.fall_trigger();
		rd(8'hCA);
		check(rv, 8'hCD);
		rd(8'hC8);
		check(rv, 8'h01);
		wr(8'hC9, 8'h01);
		wr(8'hC8, 8'h09);
		u_pins.fall_trigger();
		rd(8'hCC);
		check(rv, 8'h66);
		check({7'h00, tmr_irq}, 8'h00);
		wr(8'hCE, 8'h40);
		idle(2);
		check({7'h00, tmr_irq}, 8'h00);
		rd(8'hC8);
		check(rv, 8'h49);
		wr(8'hCF, 8'h40);
		wr(8'hC9, 8'h00);
		wr(8'hC8, 8'h08);
		u_pins.fall_trigger();
		rd(8'hCC);
		check(rv, 8'hCD);
	endtask : sc_trigger

	task sc_counter();
		wr(8'hCC, 8'h00);
		wr(8'hCD, 8'h00);
		wr(8'hC8, 8'h06);
		u_pins.pulse_count(5);
		wr(8'hCF, 8'h04);
		rd(8'hCC);
		check(rv, 8'h05);
		idle(30);
		rd(8'hCC);
		check(rv, 8'h05);
		// up/down: trigger low counts down, wraps past the reload value
		wr(8'hC9, 8'h01);
		wr(8'hCA, 8'h04);
		wr(8'hCB, 8'h00);
		u_pins.hold_trigger(1'b0);
		wr(8'hC8, 8'h04);
		wait_ev(0, 100);
		wr(8'hCF, 8'h04);
		rd(8'hCD);
		check(rv, 8'hFF);
		rd(8'hCC);
		check(rv, 8'hFF);
		u_pins.hold_trigger(1'b1);
		wr(8'hC9, 8'h00);
	endtask : sc_counter

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		sc_reset();
		sc_overflow();
		sc_baud();
		sc_trigger();
		sc_counter();
		conclude();
	end
endmodule : test_timer2_capture_reload_control
`default_nettype wire
